//--- homing_ip_ctrl.v
// Homing sequencer and interpolated position engine of the drive.
// Assumes all inputs but arst_n synchronous to sys_clk; switch levels are active high.
`timescale 1ns/1ps
`include "homing_ip_defs.vh"

// Contract
// - Method number selects edge, block, index, direction
// - Methods 1 to 14 end on index
// - Methods 17 to 30 skip index, same travel
// - Negative method number means block homing
// - Only listed negative methods accepted for block
// - Block homing needs closed loop
// - Block seen above current level, push timed
// - Methods 1/2 use negative/positive limit
// - Methods 3/4 left edge, 5/6 right
// - Methods 7-14 honour positive/negative limit
// - Methods 33/34 take next index only
// - Method 35 takes present position, any state
// - Mode value 7 selects interpolation
// - Control bit 4 activates interpolation
// - Halt release starts ramp; held halt stops
// - Halt set brakes with chosen deceleration
// - Status bit 10 target reached or stopped
// - Status bit 11 flags software limit breach
// - Status bit 12 shows interpolation active
// - Linear path to single buffered target; code buffers two targets
// - Interpolation follows SYNC once operational
// - Mode value 6 selects homing
// - Bit 4 runs homing until done, failed or cleared
// - Homing state on status bits 13, 12, 10
module homing_ip_ctrl #(
    parameter integer TICK_CYCLES = `MS_TICK_CYCLES
) (
    input wire sys_clk,
    input wire arst_n,
    input wire [7:0] mode_sel,
    input wire [15:0] control_word,
    input wire [7:0] homing_method,
    input wire closed_loop,
    input wire op_enabled,
    input wire nmt_operational,
    input wire sync_pulse,
    input wire lim_neg,
    input wire lim_pos,
    input wire home_sw,
    input wire index_pulse,
    input wire axis_speed_zero,
    input wire [15:0] motor_current,
    input wire [15:0] block_current_level,
    input wire [15:0] block_time_ms,
    input wire [2:0] halt_option,
    input wire [7:0] interp_period_ms,
    input wire buffer_enable,
    input wire [31:0] sw_limit_min,
    input wire [31:0] sw_limit_max,
    input wire [31:0] actual_position,
    input wire target_wr_valid,
    output wire target_wr_ready,
    input wire [31:0] target_wr_data,
    output reg [15:0] status_word,
    output reg [31:0] demand_position,
    output reg homing_move,
    output reg homing_dir_pos,
    output reg home_zero_set,
    output reg halt_brake,
    output reg [2:0] halt_decel_sel,
    output reg start_ramp
);

// ----------------------------------------------------------------
// Homing method decoding
// ----------------------------------------------------------------
localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_SEARCH = 7'h02;
localparam [6:0] ST_PUSH = 7'h04;
localparam [6:0] ST_INDEX = 7'h08;
localparam [6:0] ST_SETTLE = 7'h10;
localparam [6:0] ST_DONE = 7'h20;
localparam [6:0] ST_ERROR = 7'h40;

// Returns {ok, index, block, right edge, start positive, kind}
function [7:0] decode_method;
    input [7:0] m;
    reg neg;
    reg ok;
    reg idx;
    reg right;
    reg dpos;
    reg [2:0] kind;
    reg [7:0] mag;
    reg [7:0] base;
    begin
        neg = m[7];
        mag = neg ? (8'h00 - m) : m;
        ok = 1'b0;
        idx = 1'b1;
        right = 1'b0;
        dpos = 1'b0;
        kind = `KIND_LIMIT;
        base = mag;
        if (mag >= `HM_NOIDX_FIRST && mag <= `HM_NOIDX_LAST) begin
            idx = 1'b0;
            base = mag - `HM_NOIDX_OFFSET;
        end
        if (base >= `HM_FIRST && base <= `HM_NEGLIM_LAST) begin
            ok = 1'b1;
            if (base <= `HM_LIMIT_LAST) begin
                dpos = (base == `HM_LIMIT_LAST);
            end else if (base <= `HM_LEFT_LAST) begin
                kind = `KIND_HOME;
                dpos = (base == `HM_LEFT_LAST - 8'h01);
            end else if (base <= `HM_RIGHT_LAST) begin
                kind = `KIND_HOME;
                right = 1'b1;
                dpos = (base == `HM_RIGHT_LAST);
            end else if (base <= `HM_POSLIM_LAST) begin
                kind = `KIND_HOMELIM_POS;
                right = (base >= `HM_POSLIM_LAST - 8'h01);
                dpos = 1'b1;
            end else begin
                kind = `KIND_HOMELIM_NEG;
                right = (base <= `HM_NEGLIM_LAST - 8'h02);
            end
        end
        if (mag == `HM_NEXT_IDX_NEG || mag == `HM_NEXT_IDX_POS) begin
            ok = 1'b1;
            kind = `KIND_NEXT_IDX;
            dpos = (mag == `HM_NEXT_IDX_POS);
        end
        if (mag == `HM_CURRENT) begin
            ok = 1'b1;
            idx = 1'b0;
            kind = `KIND_CURRENT;
        end
        if (neg) begin
            ok = ok & (kind != `KIND_HOME) & (mag <= `HM_NOIDX_LAST);
        end
        decode_method = {ok, idx, neg, right, dpos, kind};
    end
endfunction

// ----------------------------------------------------------------
// Reset release and millisecond tick
// ----------------------------------------------------------------
reg rst_meta;
reg rst_n;
reg [`TICK_W-1:0] tick_cnt;
reg ms_tick;

// Two-stage release of the asynchronous reset
always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        rst_meta <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n <= rst_meta;
    end
end

// Tick counter realigned on every SYNC while operational
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tick_cnt <= {`TICK_W{1'b0}};
        ms_tick <= 1'b0;
    end else if (sync_pulse && nmt_operational) begin
        tick_cnt <= {`TICK_W{1'b0}};
        ms_tick <= 1'b0;
    end else if ({15'h0000, tick_cnt} == TICK_CYCLES - 1) begin
        tick_cnt <= {`TICK_W{1'b0}};
        ms_tick <= 1'b1;
    end else begin
        tick_cnt <= tick_cnt + {{(`TICK_W-1){1'b0}}, 1'b1};
        ms_tick <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Homing sequencer
// ----------------------------------------------------------------
reg [6:0] hstate;
reg [6:0] next_hstate;
reg h_idx;
reg h_block;
reg h_right;
reg h_dir;
reg next_h_dir;
reg [2:0] h_kind;
reg [15:0] push_ms;
reg start_prev;
reg home_prev;
reg index_prev;
reg next_zero_set;
wire [7:0] dec;
wire start_bit;
wire in_homing;
wire index_rise;
wire edge_hit;
wire obstacle;

assign dec = decode_method(homing_method);
assign start_bit = control_word[`CW_START_BIT];
assign in_homing = (mode_sel == `MODE_HOMING);
assign index_rise = index_pulse & ~index_prev;
assign edge_hit = (h_dir ^ h_right) ? (home_sw & ~home_prev) : (~home_sw & home_prev);
assign obstacle = h_block ? (motor_current > block_current_level) :
                  (h_dir ? lim_pos : lim_neg);

// Next homing state
always @* begin
    next_hstate = hstate;
    next_h_dir = h_dir;
    next_zero_set = 1'b0;
    case (hstate)
        ST_IDLE: begin
            if (in_homing && start_bit && !start_prev && dec[7] &&
                (!dec[5] || closed_loop)) begin
                if (dec[2:0] == `KIND_CURRENT) begin
                    next_hstate = ST_SETTLE;
                    next_zero_set = 1'b1;
                end else if (op_enabled) begin
                    next_hstate = ST_SEARCH;
                    next_h_dir = dec[3];
                end
            end
        end
        ST_SEARCH: begin
            if (h_kind == `KIND_NEXT_IDX) begin
                if (index_rise) begin
                    next_hstate = ST_SETTLE;
                    next_zero_set = 1'b1;
                end
            end else if (h_kind == `KIND_LIMIT) begin
                if (obstacle && h_block) begin
                    next_hstate = ST_PUSH;
                end else if (obstacle) begin
                    next_hstate = h_idx ? ST_INDEX : ST_SETTLE;
                    next_h_dir = ~h_dir;
                    next_zero_set = ~h_idx;
                end
            end else if (edge_hit) begin
                next_hstate = h_idx ? ST_INDEX : ST_SETTLE;
                next_zero_set = ~h_idx;
            end else if (obstacle) begin
                if (h_kind == `KIND_HOME) begin
                    next_hstate = ST_ERROR;
                end else begin
                    next_h_dir = ~h_dir;
                end
            end
        end
        ST_PUSH: begin
            if (push_ms >= block_time_ms) begin
                next_hstate = h_idx ? ST_INDEX : ST_SETTLE;
                next_h_dir = ~h_dir;
                next_zero_set = ~h_idx;
            end
        end
        ST_INDEX: begin
            if (index_rise) begin
                next_hstate = ST_SETTLE;
                next_zero_set = 1'b1;
            end
        end
        ST_SETTLE: begin
            if (axis_speed_zero) begin
                next_hstate = ST_DONE;
            end
        end
        ST_DONE: begin
            next_hstate = ST_DONE;
        end
        ST_ERROR: begin
            next_hstate = ST_ERROR;
        end
        default: begin
            next_hstate = ST_IDLE;
        end
    endcase
    if ((hstate & (ST_SEARCH | ST_PUSH | ST_INDEX)) != 7'h00) begin
        if (!op_enabled || (h_block && !closed_loop)) begin
            next_hstate = ST_ERROR;
            next_zero_set = 1'b0;
        end
    end
    if (!start_bit || !in_homing) begin
        next_hstate = ST_IDLE;
        next_zero_set = 1'b0;
    end
end

// Homing registers and drive outputs
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        hstate <= ST_IDLE;
        h_idx <= 1'b0;
        h_block <= 1'b0;
        h_right <= 1'b0;
        h_dir <= 1'b0;
        h_kind <= `KIND_LIMIT;
        push_ms <= 16'h0000;
        start_prev <= 1'b0;
        home_prev <= 1'b0;
        index_prev <= 1'b0;
        homing_move <= 1'b0;
        homing_dir_pos <= 1'b0;
        home_zero_set <= 1'b0;
    end else begin
        hstate <= next_hstate;
        h_dir <= next_h_dir;
        start_prev <= start_bit;
        home_prev <= home_sw;
        index_prev <= index_pulse;
        if (hstate == ST_IDLE) begin
            h_idx <= dec[6];
            h_block <= dec[5];
            h_right <= dec[4];
            h_kind <= dec[2:0];
        end
        if (hstate != ST_PUSH) begin
            push_ms <= 16'h0000;
        end else if (ms_tick) begin
            push_ms <= push_ms + 16'h0001;
        end
        homing_move <= ((next_hstate & (ST_SEARCH | ST_PUSH | ST_INDEX)) != 7'h00);
        homing_dir_pos <= next_h_dir;
        home_zero_set <= next_zero_set;
    end
end

// ----------------------------------------------------------------
// Interpolated position engine
// ----------------------------------------------------------------
reg [31:0] seg_target;
reg [7:0] seg_ticks;
reg [32:0] div_q;
reg [8:0] div_rem;
reg [5:0] div_cnt;
reg div_neg;
reg [32:0] step;
reg halt_prev;
wire ip_active;
wire halt_bit;
wire buf_valid;
wire [31:0] buf_data;
wire seg_pop;
wire [32:0] delta;
wire [7:0] period;
wire [8:0] rem_sh;
wire rem_ge;

assign halt_bit = control_word[`CW_HALT_BIT];
assign ip_active = (mode_sel == `MODE_INTERP) && control_word[`CW_START_BIT] && op_enabled;
assign period = (interp_period_ms == 8'h00) ? 8'h01 : interp_period_ms;
assign seg_pop = ip_active && nmt_operational && sync_pulse && !halt_bit && buf_valid &&
                 (seg_ticks == 8'h00) && (div_cnt == 6'h00);
assign delta = {buf_data[31], buf_data} - {demand_position[31], demand_position};
assign rem_sh = {div_rem[7:0], div_q[32]};
assign rem_ge = (rem_sh >= {1'b0, period});

// Target buffer, writable only while the host enables it
target_buffer #(
    .WIDTH(32)
) u_target_buffer (
    .clk(sys_clk),
    .rst_n(rst_n),
    .accept_en(buffer_enable),
    .in_valid(target_wr_valid),
    .in_ready(target_wr_ready),
    .in_data(target_wr_data),
    .out_valid(buf_valid),
    .out_ready(seg_pop),
    .out_data(buf_data)
);

// Segment divider and per-millisecond linear stepping
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        seg_target <= 32'h00000000;
        seg_ticks <= 8'h00;
        div_q <= 33'h000000000;
        div_rem <= 9'h000;
        div_cnt <= 6'h00;
        div_neg <= 1'b0;
        step <= 33'h000000000;
        demand_position <= 32'h00000000;
    end else if (!ip_active) begin
        seg_ticks <= 8'h00;
        div_cnt <= 6'h00;
        demand_position <= actual_position;
        seg_target <= actual_position;
    end else if (seg_pop) begin
        seg_target <= buf_data;
        div_neg <= delta[32];
        div_q <= delta[32] ? (33'h000000000 - delta) : delta;
        div_rem <= 9'h000;
        div_cnt <= `DIV_STEPS;
    end else if (div_cnt != 6'h00) begin
        div_rem <= rem_ge ? (rem_sh - {1'b0, period}) : rem_sh;
        div_q <= {div_q[31:0], rem_ge};
        div_cnt <= div_cnt - 6'h01;
        if (div_cnt == 6'h01) begin
            step <= div_neg ? (33'h000000000 - {div_q[31:0], rem_ge}) : {div_q[31:0], rem_ge};
            seg_ticks <= period;
        end
    end else if (ms_tick && !halt_bit && seg_ticks != 8'h00) begin
        seg_ticks <= seg_ticks - 8'h01;
        if (seg_ticks == 8'h01) begin
            demand_position <= seg_target;
        end else begin
            demand_position <= demand_position + step[31:0];
        end
    end
end

// Halt edges: braking selection and start ramp
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        halt_prev <= 1'b0;
        halt_brake <= 1'b0;
        halt_decel_sel <= 3'h0;
        start_ramp <= 1'b0;
    end else begin
        halt_prev <= halt_bit;
        halt_brake <= halt_bit;
        start_ramp <= halt_prev & ~halt_bit;
        if (halt_bit && !halt_prev) begin
            halt_decel_sel <= halt_option;
        end
    end
end

// ----------------------------------------------------------------
// Status word
// ----------------------------------------------------------------
reg [15:0] next_status;

// Mode-dependent status bits
always @* begin
    next_status = `STATUS_RESET;
    if (mode_sel == `MODE_INTERP) begin
        next_status[`SW_ACTIVE_BIT] = ip_active;
        next_status[`SW_LIMIT_BIT] = ($signed(demand_position) < $signed(sw_limit_min)) ||
                                     ($signed(demand_position) > $signed(sw_limit_max));
        next_status[`SW_TARGET_BIT] = halt_bit ? axis_speed_zero :
            (ip_active && seg_ticks == 8'h00 && div_cnt == 6'h00 &&
             actual_position == seg_target);
    end else if (in_homing) begin
        case (hstate)
            ST_IDLE: next_status[`SW_TARGET_BIT] = 1'b1;
            ST_SETTLE: next_status[`SW_ACTIVE_BIT] = 1'b1;
            ST_DONE: begin
                next_status[`SW_ACTIVE_BIT] = 1'b1;
                next_status[`SW_TARGET_BIT] = 1'b1;
            end
            ST_ERROR: begin
                next_status[`SW_ERROR_BIT] = 1'b1;
                next_status[`SW_TARGET_BIT] = axis_speed_zero;
            end
            default: next_status = `STATUS_RESET;
        endcase
    end
end

// Registered status output
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        status_word <= `STATUS_RESET;
    end else begin
        status_word <= next_status;
    end
end

endmodule

//--- homing_ip_defs.vh
// Constants shared by the homing and interpolated position logic.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef HOMING_IP_DEFS_VH
`define HOMING_IP_DEFS_VH

// ------------
// Operating mode selector values
// ------------
`define MODE_HOMING 8'h06
`define MODE_INTERP 8'h07

// ------------
// Control and status bit positions
// ------------
`define CW_START_BIT 4
`define CW_HALT_BIT 8
`define SW_TARGET_BIT 10
`define SW_LIMIT_BIT 11
`define SW_ACTIVE_BIT 12
`define SW_ERROR_BIT 13
`define STATUS_RESET 16'h0000

// ------------
// Homing method numbers
// ------------
`define HM_FIRST 8'h01
`define HM_LIMIT_LAST 8'h02
`define HM_LEFT_LAST 8'h04
`define HM_RIGHT_LAST 8'h06
`define HM_POSLIM_LAST 8'h0a
`define HM_NEGLIM_LAST 8'h0e
`define HM_NOIDX_FIRST 8'h11
`define HM_NOIDX_LAST 8'h1e
`define HM_NOIDX_OFFSET 8'h10
`define HM_NEXT_IDX_NEG 8'h21
`define HM_NEXT_IDX_POS 8'h22
`define HM_CURRENT 8'h23

// ------------
// Homing reference kinds
// ------------
`define KIND_LIMIT 3'h0
`define KIND_HOME 3'h1
`define KIND_HOMELIM_POS 3'h2
`define KIND_HOMELIM_NEG 3'h3
`define KIND_NEXT_IDX 3'h4
`define KIND_CURRENT 3'h5

// ------------
// Timing
// ------------
`define MS_TICK_CYCLES 125000
`define TICK_W 17
`define DIV_STEPS 6'h21

`endif

//--- target_buffer.v
// Two-entry buffer for interpolation targets with valid/ready on both sides.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/1ps

module target_buffer #(
    parameter WIDTH = 32
) (
    input wire clk,
    input wire rst_n,
    input wire accept_en,
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] tail;
reg [1:0] count;
reg [1:0] next_count;
wire push;
wire pop;

assign push = in_valid & in_ready;
assign out_valid = (count != 2'h0);
assign pop = out_valid & out_ready;

// Occupancy after this cycle
always @* begin
    next_count = count;
    if (push & ~pop) begin
        next_count = count + 2'h1;
    end else if (pop & ~push) begin
        next_count = count - 2'h1;
    end
end

// Head register feeds the reader directly
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        count <= 2'h0;
        in_ready <= 1'b0;
        out_data <= {WIDTH{1'b0}};
        tail <= {WIDTH{1'b0}};
    end else begin
        count <= next_count;
        in_ready <= accept_en & (next_count != 2'h2);
        if (push & ~pop) begin
            if (count == 2'h0) begin
                out_data <= in_data;
            end else begin
                tail <= in_data;
            end
        end else if (push & pop) begin
            if (count == 2'h1) begin
                out_data <= in_data;
            end else begin
                out_data <= tail;
                tail <= in_data;
            end
        end else if (pop) begin
            out_data <= tail;
        end
    end
end

endmodule

//--- homing_ip_monitor.sv
// Port assertions for the homing and interpolation controller.
// Assumes binding to homing_ip_ctrl; status lags its inputs one cycle.
`timescale 1ns/1ps
`include "homing_ip_defs.vh"

module homing_ip_monitor #(
    parameter integer TICK_CYCLES = 20
) (
    input wire sys_clk,
    input wire arst_n,
    input wire [7:0] mode_sel,
    input wire [15:0] control_word,
    input wire [7:0] homing_method,
    input wire closed_loop,
    input wire op_enabled,
    input wire lim_pos,
    input wire [2:0] halt_option,
    input wire [31:0] sw_limit_min,
    input wire [31:0] sw_limit_max,
    input wire [15:0] status_word,
    input wire [31:0] demand_position,
    input wire homing_move,
    input wire homing_dir_pos,
    input wire home_zero_set,
    input wire halt_brake,
    input wire [2:0] halt_decel_sel,
    input wire start_ramp
);
    reg [1:0] rel_cnt;
    wire live = (rel_cnt == 2'h3);
    wire lo = $signed(demand_position) < $signed(sw_limit_min);
    wire out_lim = lo || $signed(demand_position) > $signed(sw_limit_max);
    wire ip_on = mode_sel == `MODE_INTERP && control_word[4] && op_enabled;
    wire bad_m = homing_method inside {8'h00, 8'h0f, 8'h10, 8'h1f, 8'h20, 8'h24,
        8'hfd, 8'hec, 8'hdf};

    // Edges since release
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rel_cnt <= 2'h0;
        end else if (!live) begin
            rel_cnt <= rel_cnt + 2'h1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!live);

    sequence hstart;
        mode_sel == `MODE_HOMING && $rose(control_word[4]);
    endsequence

    halt_track_a: assert property (halt_brake == $past(control_word[8]))
        else $error("brake lag");
    halt_decel_a: assert property ($rose(control_word[8]) |=>
        halt_decel_sel == $past(halt_option)) else $error("decel not held");
    ramp_start_a: assert property ($fell(control_word[8]) |=> start_ramp)
        else $error("no ramp");
    ip_active_a: assert property (mode_sel == `MODE_INTERP |=>
        status_word[12] == $past(ip_on)) else $error("bit 12");
    limit_flag_a: assert property (mode_sel == `MODE_INTERP |=>
        status_word[11] == $past(out_lim)) else $error("bit 11");
    here_zero_a: assert property (hstart ##0 homing_method == `HM_CURRENT
        |=> home_zero_set) else $error("no zero");
    bad_method_a: assert property (hstart ##0 bad_m |=> !homing_move [*2])
        else $error("bad method moved");
    block_loop_a: assert property (hstart ##0 homing_method[7] && !closed_loop
        |=> !homing_move ##1 !homing_move) else $error("open loop block");
    homing_go_a: assert property (hstart ##0 homing_method == 8'h12 && op_enabled
        |=> homing_move && homing_dir_pos) else $error("no start");
    limit_ref_a: assert property (homing_move && homing_method == 8'h12 && lim_pos
        && mode_sel == `MODE_HOMING && control_word[4] && op_enabled
        |=> home_zero_set && !homing_move) else $error("no limit ref");
endmodule

bind homing_ip_ctrl homing_ip_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.*);

//--- host_model.sv
// Motion controller model: target writes and SYNC events.
// Assumes callers enter tasks just after a rising edge.
`timescale 1ns/1ps

module host_model (
    input wire sys_clk,
    input wire target_wr_ready,
    output logic target_wr_valid,
    output logic [31:0] target_wr_data,
    output logic sync_pulse
);
    initial begin
        target_wr_valid = 1'h0;
        target_wr_data = 32'h0;
        sync_pulse = 1'h0;
    end

    // Offer a target until taken or 100 cycles pass
    task automatic send(input logic [31:0] w, output bit ok);
        ok = 0;
        target_wr_valid = 1'h1;
        target_wr_data = w;
        for (int i = 0; i < 100 && !ok; i++) begin
            ok = target_wr_ready;
            @(posedge sys_clk);
            #1;
        end
    endtask

    // Drop valid, scramble data
    task idle;
        target_wr_valid = 1'h0;
        target_wr_data = ~target_wr_data;
    endtask

    // One-cycle SYNC event
    task sync;
        sync_pulse = 1'h1;
        @(posedge sys_clk);
        #1;
        sync_pulse = 1'h0;
    endtask
endmodule

//--- tb_homing_and_interpolated_position.sv
// Self-checking bench for the homing and interpolated position controller.
// Assumes the host model supplies targets; actual position follows demand.
`timescale 1ns/1ps

module tb_homing_and_interpolated_position;
    logic sys_clk = 0, arst_n = 0, closed_loop = 1, op_enabled = 1, nmt_operational = 0;
    logic lim_neg = 0, lim_pos = 0, home_sw = 0, index_pulse = 0, axis_speed_zero = 0;
    logic buffer_enable = 0;
    logic [7:0] mode_sel = 0, homing_method = 0, interp_period_ms = 8'h02;
    logic [15:0] control_word = 0, motor_current = 0;
    logic [15:0] block_current_level = 16'h0100, block_time_ms = 16'h0002;
    logic [2:0] halt_option = 0;
    logic [31:0] sw_limit_min = 32'hffff_fc18, sw_limit_max = 32'h0000_2710;
    wire [31:0] actual_position, target_wr_data, demand_position;
    wire target_wr_valid, target_wr_ready, sync_pulse, homing_move, homing_dir_pos;
    wire home_zero_set, halt_brake, start_ramp;
    wire [15:0] status_word;
    wire [2:0] halt_decel_sel;
    int bad_count = 0, checked = 0, i;
    bit ok;
    // Rows: method, expected motion, expected positive direction
    logic [9:0] rows [27] = '{10'h006, 10'h00b, 10'h00f, 10'h012, 10'h016, 10'h01b,
        10'h01f, 10'h02e, 10'h03a, 10'h046, 10'h04b, 10'h06b, 10'h086, 10'h08b, 10'h3fe,
        10'h3bb, 10'h3ca, 10'h3a7, 10'h000, 10'h03c, 10'h040, 10'h07c, 10'h080, 10'h090,
        10'h3f4, 10'h3b0, 10'h37c};

    assign actual_position = demand_position;
    always #4 sys_clk = ~sys_clk;

    homing_ip_ctrl #(.TICK_CYCLES(20)) u_dut (.*);
    host_model u_host (.*);

    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task give_verdict;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task bound(input int n);
        if (i >= n) begin
            bad_count++;
            give_verdict();
        end
    endtask

    task start(input logic [7:0] m);
        homing_method = m;
        control_word[4] = 1'h1;
        step(3);
    endtask

    task stop;
        control_word[4] = 1'h0;
        step(2);
    endtask

    function logic [2:0] hs();
        return {status_word[13], status_word[12], status_word[10]};
    endfunction

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        step(10);
        chk(target_wr_ready, 1'h0);
        chk(status_word, 16'h0);
        arst_n = 1;
        step(3);
        mode_sel = 8'h06;
        foreach (rows[r]) begin
            start(rows[r][9:2]);
            chk(homing_move, rows[r][1]);
            chk(homing_dir_pos & homing_move, rows[r][0]);
            chk(hs(), rows[r][1] ? 3'h0 : 3'h1);
            {home_sw, lim_neg, index_pulse} = 3'h7;
            step(1);
            {home_sw, lim_neg, index_pulse} = 3'h0;
            stop();
        end
        // Method 35, power stage off
        op_enabled = 0;
        axis_speed_zero = 1;
        homing_method = 8'h23;
        control_word[4] = 1'h1;
        step(1);
        chk(home_zero_set, 1'h1);
        for (i = 0; i < 20 && hs() !== 3'h3; i++) step(1);
        bound(20);
        chk(hs(), 3'h3);
        stop();
        // Limit walk, confirmed then complete
        op_enabled = 1;
        axis_speed_zero = 0;
        start(8'h12);
        lim_pos = 1;
        step(1);
        chk(home_zero_set, 1'h1);
        step(1);
        chk(hs(), 3'h2);
        axis_speed_zero = 1;
        for (i = 0; i < 20 && hs() !== 3'h3; i++) step(1);
        bound(20);
        chk(hs(), 3'h3);
        lim_pos = 0;
        stop();
        // Power stage lost mid search
        axis_speed_zero = 0;
        start(8'h12);
        op_enabled = 0;
        step(3);
        chk(hs(), 3'h4);
        op_enabled = 1;
        stop();
        // Block: open loop refused, then push
        closed_loop = 0;
        start(8'hff);
        chk(hs(), 3'h1);
        closed_loop = 1;
        stop();
        start(8'hee);
        motor_current = 16'h0200;
        for (i = 0; i < 300 && home_zero_set !== 1'h1; i++) step(1);
        bound(300);
        chk(i >= 20, 1'h1);
        motor_current = 0;
        stop();
        // Interpolation, two segments
        mode_sel = 8'h07;
        control_word[4] = 1'h1;
        buffer_enable = 1;
        step(3);
        chk(status_word[12], 1'h1);
        u_host.send(32'h3e8, ok);
        chk(ok, 1'h1);
        u_host.send(32'hbb8, ok);
        chk(ok, 1'h1);
        u_host.idle();
        step(1);
        chk(target_wr_ready, 1'h0);
        u_host.sync();
        step(40);
        chk(demand_position, 32'h0);
        nmt_operational = 1;
        u_host.sync();
        for (i = 0; i < 300 && demand_position === 32'h0; i++) step(1);
        bound(300);
        chk(demand_position, 32'h1f4);
        for (i = 0; i < 300 && demand_position !== 32'h3e8; i++) step(1);
        bound(300);
        step(2);
        chk(target_wr_ready, 1'h1);
        chk(status_word[10], 1'h1);
        sw_limit_max = 32'h2bc;
        step(2);
        chk(status_word[11], 1'h1);
        control_word[8] = 1'h1;
        halt_option = 3'h5;
        axis_speed_zero = 1;
        step(2);
        chk(halt_decel_sel, 3'h5);
        chk(halt_brake, 1'h1);
        chk(status_word[10], 1'h1);
        axis_speed_zero = 0;
        step(2);
        chk(status_word[10], 1'h0);
        control_word[8] = 1'h0;
        step(1);
        chk(start_ramp, 1'h1);
        u_host.sync();
        for (i = 0; i < 300 && demand_position !== 32'hbb8; i++) step(1);
        bound(300);
        chk(demand_position, 32'hbb8);
        give_verdict();
    end
endmodule
